// ---- core/ldc_pkg.sv ----
// Package for the laser driver control register bank.
// Assumes a two-wire serial slave front end and an 8-bit register file.
`default_nettype none
package ldc_pkg;
  // Slave address and register offsets
  localparam logic [6:0] SLAVE_ADDR        = 7'h08;
  localparam logic [7:0] OFF_CHIP          = 8'h00;
  localparam logic [7:0] OFF_BIAS_LOOP     = 8'h01;
  localparam logic [7:0] OFF_SPARE         = 8'h02;
  localparam logic [7:0] OFF_CONVERTER     = 8'h03;
  localparam logic [7:0] OFF_TX_PATH       = 8'h0A;
  localparam logic [7:0] OFF_AMP_EQ        = 8'h0B;
  localparam logic [7:0] OFF_MOD_LEVEL     = 8'h0C;
  localparam logic [7:0] OFF_OUT_MODE      = 8'h0D;
  localparam logic [7:0] OFF_CROSSPOINT    = 8'h0E;
  localparam logic [7:0] OFF_BIAS_HIGH     = 8'h0F;
  localparam logic [7:0] OFF_BIAS_LOW      = 8'h10;
  localparam int         REG_COUNT         = 17;
  // Reset values and chip register bit positions
  localparam logic [7:0] RST_CHIP          = 8'h41;
  localparam logic [7:0] RST_OTHER         = 8'h00;
  localparam logic [7:0] CHIP_WR_MASK      = 8'h79;
  localparam int         BIT_GLOBAL_RST    = 7;
  localparam int         BIT_IF_RST        = 1;
  localparam int         BIT_CHIP_EN       = 0;
  localparam logic [3:0] BITS_PER_BYTE     = 4'h8;
  localparam logic [1:0] BYTE_DEV          = 2'h0;
  localparam logic [1:0] BYTE_REG          = 2'h1;
  localparam logic [1:0] BYTE_DATA         = 2'h2;

  // Serial front end states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } ldc_state_t;

  // Request passed from the link side to the register side
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } ldc_req_t;

  // Decoded control fields
  typedef struct packed {
    logic       chip_enable;
    logic       analog_pd_fault_trigger;
    logic [1:0] pd_range_select;
    logic       open_loop_select;
    logic       fault_detect_enable;
    logic       bias_current_enable;
    logic       bias_sink_select;
    logic       pd_orientation_select;
    logic       converter_enable;
    logic       converter_osc_enable;
    logic       converter_reset;
    logic [2:0] converter_input_select;
    logic       transmit_power_down;
    logic       output_driver_off;
    logic       output_invert;
    logic       recovery_disable;
    logic       recovery_bypass;
    logic       offset_cancel_off;
    logic       equalizer_off;
    logic       analog_amplitude_select;
    logic       half_amplitude_select;
    logic       wide_peaking_select;
    logic [1:0] temp_comp_select;
    logic [3:0] input_eq_strength;
    logic [7:0] modulation_setting;
    logic       negative_output_select;
    logic       single_ended_select;
    logic       delayed_deemphasis_select;
    logic       slow_edge_select;
    logic [3:0] deemphasis_strength;
    logic       crosspoint_direction;
    logic [6:0] crosspoint_magnitude;
    logic [9:0] bias_setting;
  } ldc_ctrl_t;
endpackage
`default_nettype wire

// ---- core/ldc_regs.sv ----
// Register bank of the laser driver with its two-wire serial slave.
// Assumes scl/sda arrive as pins sampled by link_clk, which is much faster than scl.
`default_nettype none

// Summary of operation
// R1 - After reset the output stage drives both outputs differentially.
// R2 - Mode bit selects single-ended; select bit swaps positive for negative output.
// R3 - Write: start, address, write bit, ack, register, ack, data, ack, stop.
// R4 - Read: register write phase, repeated start, read address, data out, master nack.
// R5 - Global reset bit restores all registers and storage; reads back zero.
// R6 - Interface reset bit restores all registers; reads back zero.
// R7 - Chip enable bit, reset one; chip register resets to 41 hex.
// R8 - Two-bit photodiode range field selects full scale and resolution.
// R9 - Bit selects open-loop bias or closed-loop power control.
// R10 - Fault detection enable and analog monitor fault trigger enable.
// R11 - Bias enable bit; dropping it clears a latched fault.
// R12 - Bias sink or source, photodiode orientation bits.
// R13 - Converter enable, oscillator enable, converter reset bits, all reset zero.
// R14 - Converter input select field; codes 1XX are reserved.
// R15 - Power down, output driver off, output invert bits, reset zero.
// R16 - Recovery disable, recovery bypass, offset cancel off, equalizer off bits.
// R17 - Analog amplitude select and half amplitude range select.
// R18 - Wide peaking, temperature compensation, input equalizer strength fields.
// R19 - Eight-bit modulation setting.
// R20 - Delayed de-emphasis, slow edge, de-emphasis strength fields.
// R21 - Cross-point direction and seven-bit magnitude.
// R22 - Ten-bit bias setting, upper eight bits in register 15.
// R23 - Answers only slave address 0001000, never starts transfers.
// R24 - One data byte per transaction.
// R25 - Enabled fault zeroes bias, latches fault pin and fault flag.
// R26 - Lower two bias bits live in register 16 bits 1:0.
// R27 - Reserved read/write bits store and return written values; chip register bit 2 is masked off by CHIP_WR_MASK and reads zero.
module ldc_regs
  import ldc_pkg::*;
(
  // Register side clock and reset
  input  wire logic      ref_clk,
  input  wire logic      rst,
  // Link clock
  input  wire logic      link_clk,
  // Serial pins, open drain data
  input  wire logic      scl_i,
  input  wire logic      sda_i,
  output logic           sda_o,
  output logic           sda_oe,
  // Fault sources from the analog side
  input  wire logic      fault_cond_i,
  input  wire logic      pd_monitor_pin_i,
  // Control outputs
  output ldc_ctrl_t      ctrl,
  output logic           positive_output_en,
  output logic           negative_output_en,
  output logic           bias_drive_en,
  output logic           fault_pin,
  output logic           fault_flag,
  output logic           nv_reset
);

  // ---------------- Link domain ----------------
  logic       lrst_s1_q, lrst_s2_q;
  logic       scl_s1_q, scl_s2_q, scl_p_q;
  logic       sda_s1_q, sda_s2_q, sda_p_q;
  logic       start_det, stop_det, scl_rise, scl_fall;
  ldc_state_t st_q;
  logic [3:0] cnt_q;
  logic [1:0] idx_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic       rw_q;
  logic       sda_oe_q;
  ldc_req_t   req_q;
  logic       req_tgl_q;
  logic       ack_s1_q, ack_s2_q, ack_s3_q;
  logic [7:0] rd_byte_q;
  // Answer word and toggle from the register side, read by the capture below
  logic       ack_tgl_q;
  logic [7:0] rdata_q;

  // Reset and pin synchronisers
  always_ff @(posedge link_clk) begin
    lrst_s1_q <= rst;
    lrst_s2_q <= lrst_s1_q;
    scl_s1_q  <= scl_i;
    scl_s2_q  <= scl_s1_q;
    scl_p_q   <= scl_s2_q;
    sda_s1_q  <= sda_i;
    sda_s2_q  <= sda_s1_q;
    sda_p_q   <= sda_s2_q;
  end

  // Bus conditions from synchronised levels
  assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_det  = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
  assign scl_rise  = scl_s2_q & ~scl_p_q;
  assign scl_fall  = ~scl_s2_q & scl_p_q;

  // Serial slave state machine
  always_ff @(posedge link_clk) begin
    if (lrst_s2_q) begin
      st_q     <= ST_IDLE;
      cnt_q    <= 4'h0;
      idx_q    <= BYTE_DEV;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      rw_q     <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      st_q     <= ST_RX;             // R4
      cnt_q    <= 4'h0;
      idx_q    <= BYTE_DEV;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      st_q     <= ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          sda_oe_q <= 1'b0;          // R23
        end
        ST_RX: begin
          if (scl_rise && cnt_q != BITS_PER_BYTE) begin
            shift_q <= {shift_q[6:0], sda_s2_q};
            cnt_q   <= cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            cnt_q <= 4'h0;
            if (idx_q == BYTE_DEV && shift_q[7:1] != SLAVE_ADDR) begin
              st_q <= ST_IDLE;       // R23
            end else begin
              if (idx_q == BYTE_DEV) begin
                rw_q <= shift_q[0];
              end
              st_q     <= ST_ACK;
              sda_oe_q <= 1'b1;      // R3
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (idx_q == BYTE_DEV && rw_q) begin
              st_q     <= ST_TX;     // R4
              tx_q     <= {rd_byte_q[6:0], 1'b0};
              sda_oe_q <= ~rd_byte_q[7];
              cnt_q    <= 4'h1;
            end else if (idx_q == BYTE_DATA) begin
              st_q     <= ST_IDLE;   // R24
              sda_oe_q <= 1'b0;
            end else begin
              st_q     <= ST_RX;
              idx_q    <= idx_q + 2'h1;
              sda_oe_q <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == BITS_PER_BYTE) begin
              st_q     <= ST_MACK;
              sda_oe_q <= 1'b0;
            end else begin
              sda_oe_q <= ~tx_q[7];
              tx_q     <= {tx_q[6:0], 1'b0};
              cnt_q    <= cnt_q + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            st_q <= ST_IDLE;         // R24
          end
        end
      endcase
    end
  end

  // Requests to the register side, one toggle each
  always_ff @(posedge link_clk) begin
    if (lrst_s2_q) begin
      req_q     <= '0;
      req_tgl_q <= 1'b0;
    end else if (st_q == ST_RX && scl_fall && cnt_q == BITS_PER_BYTE && !start_det && !stop_det) begin
      if (idx_q == BYTE_REG) begin
        req_q     <= '{wr: 1'b0, addr: shift_q, data: 8'h00};
        req_tgl_q <= ~req_tgl_q;     // R4
      end else if (idx_q == BYTE_DATA && !rw_q) begin
        req_q     <= '{wr: 1'b1, addr: req_q.addr, data: shift_q};
        req_tgl_q <= ~req_tgl_q;     // R3
      end
    end
  end

  // Answer capture from the register side
  always_ff @(posedge link_clk) begin
    ack_s1_q <= ack_tgl_q;
    ack_s2_q <= ack_s1_q;
    ack_s3_q <= ack_s2_q;
    if (lrst_s2_q) begin
      rd_byte_q <= 8'h00;
    end else if (ack_s2_q != ack_s3_q) begin
      rd_byte_q <= rdata_q;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_q;

  // ---------------- Register domain ----------------
  logic [7:0] regs_q [REG_COUNT];
  logic       req_s1_q, req_s2_q, req_s3_q;
  logic       req_fire, wr_fire, soft_rst;
  logic       flt_s1_q, flt_s2_q, pdm_s1_q, pdm_s2_q;
  logic       fault_q, fault_set;
  logic       nv_reset_q;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a <= OFF_CONVERTER) || ((a >= OFF_TX_PATH) && (a <= OFF_BIAS_LOW));
  endfunction

  // Request edge detection
  always_ff @(posedge ref_clk) begin
    req_s1_q <= req_tgl_q;
    req_s2_q <= req_s1_q;
    req_s3_q <= req_s2_q;
  end

  assign req_fire = req_s2_q ^ req_s3_q;
  assign wr_fire  = req_fire & req_q.wr & is_mapped(req_q.addr);
  assign soft_rst = wr_fire && req_q.addr == OFF_CHIP
                    && (req_q.data[BIT_GLOBAL_RST] || req_q.data[BIT_IF_RST]);

  // Register file
  always_ff @(posedge ref_clk) begin
    if (rst || soft_rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= (i == 0) ? RST_CHIP : RST_OTHER;  // R5 R6 R7
      end
    end else if (wr_fire) begin
      if (req_q.addr == OFF_CHIP) begin
        regs_q[0] <= req_q.data & CHIP_WR_MASK;        // R5 R6 R27
      end else begin
        regs_q[req_q.addr[4:0]] <= req_q.data;         // R27
      end
    end
  end

  // Storage reset pulse for the global reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nv_reset_q <= 1'b0;
    end else begin
      nv_reset_q <= wr_fire && req_q.addr == OFF_CHIP && req_q.data[BIT_GLOBAL_RST];  // R5
    end
  end

  // Read answer and acknowledge toggle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q   <= 8'h00;
      ack_tgl_q <= 1'b0;
    end else if (req_fire) begin
      rdata_q   <= is_mapped(req_q.addr) ? regs_q[req_q.addr[4:0]] : 8'h00;
      ack_tgl_q <= ~ack_tgl_q;
    end
  end

  // Fault pin synchronisers
  always_ff @(posedge ref_clk) begin
    flt_s1_q <= fault_cond_i;
    flt_s2_q <= flt_s1_q;
    pdm_s1_q <= pd_monitor_pin_i;
    pdm_s2_q <= pdm_s1_q;
  end

  assign fault_set = ctrl.fault_detect_enable && ctrl.bias_current_enable
                     && (flt_s2_q || (ctrl.analog_pd_fault_trigger && pdm_s2_q));  // R10 R25

  // Fault latch, cleared while bias enable is low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else if (fault_set) begin
      fault_q <= 1'b1;               // R25
    end else if (!ctrl.bias_current_enable) begin
      fault_q <= 1'b0;               // R11
    end
  end

  // Field decode
  assign ctrl.chip_enable               = regs_q[0][BIT_CHIP_EN];                   // R7
  assign ctrl.analog_pd_fault_trigger   = regs_q[1][7];                             // R10
  assign ctrl.pd_range_select           = regs_q[1][6:5];                           // R8
  assign ctrl.open_loop_select          = regs_q[1][4];                             // R9
  assign ctrl.fault_detect_enable       = regs_q[1][3];                             // R10
  assign ctrl.bias_current_enable       = regs_q[1][2];                             // R11
  assign ctrl.bias_sink_select          = regs_q[1][1];                             // R12
  assign ctrl.pd_orientation_select     = regs_q[1][0];                             // R12
  assign ctrl.converter_enable          = regs_q[3][7];                             // R13
  assign ctrl.converter_osc_enable      = regs_q[3][6];                             // R13
  assign ctrl.converter_reset           = regs_q[3][4];                             // R13
  assign ctrl.converter_input_select    = regs_q[3][2:0];                           // R14
  assign ctrl.transmit_power_down       = regs_q[10][7];                            // R15
  assign ctrl.output_driver_off         = regs_q[10][6];                            // R15
  assign ctrl.output_invert             = regs_q[10][5];                            // R15
  assign ctrl.recovery_disable          = regs_q[10][4];                            // R16
  assign ctrl.recovery_bypass           = regs_q[10][3];                            // R16
  assign ctrl.offset_cancel_off         = regs_q[10][2];                            // R16
  assign ctrl.equalizer_off             = regs_q[10][1];                            // R16
  assign ctrl.analog_amplitude_select   = regs_q[10][0];                            // R17
  assign ctrl.half_amplitude_select     = regs_q[11][7];                            // R17
  assign ctrl.wide_peaking_select       = regs_q[11][6];                            // R18
  assign ctrl.temp_comp_select          = regs_q[11][5:4];                          // R18
  assign ctrl.input_eq_strength         = regs_q[11][3:0];                          // R18
  assign ctrl.modulation_setting        = regs_q[12];                               // R19
  assign ctrl.negative_output_select    = regs_q[13][7];                            // R2
  assign ctrl.single_ended_select       = regs_q[13][6];                            // R2
  assign ctrl.delayed_deemphasis_select = regs_q[13][5];                            // R20
  assign ctrl.slow_edge_select          = regs_q[13][4];                            // R20
  assign ctrl.deemphasis_strength       = regs_q[13][3:0];                          // R20
  assign ctrl.crosspoint_direction      = regs_q[14][7];                            // R21
  assign ctrl.crosspoint_magnitude      = regs_q[14][6:0];                          // R21
  assign ctrl.bias_setting              = {regs_q[15], regs_q[16][1:0]};            // R22 R26

  // Output stage selection and bias gating
  assign positive_output_en = ~ctrl.single_ended_select | ~ctrl.negative_output_select;  // R1 R2
  assign negative_output_en = ~ctrl.single_ended_select | ctrl.negative_output_select;   // R1 R2
  assign bias_drive_en      = ctrl.bias_current_enable & ctrl.chip_enable & ~fault_q;    // R25
  assign fault_pin          = fault_q;
  assign fault_flag         = fault_q;
  assign nv_reset           = nv_reset_q;

  // ---------------- Checks ----------------
  property p_diff_default;
    @(posedge ref_clk) rst |=> positive_output_en && negative_output_en;
  endproperty
  a_diff_default: assert property (p_diff_default) else $error("outputs not differential after reset"); // R1

  property p_single_neg;
    @(posedge ref_clk) disable iff (rst)
      (ctrl.single_ended_select && ctrl.negative_output_select) |-> (!positive_output_en && negative_output_en);
  endproperty
  a_single_neg: assert property (p_single_neg) else $error("single-ended output selection wrong"); // R2

  property p_chip_reset;
    @(posedge ref_clk) rst |=> (regs_q[0] == RST_CHIP) && ctrl.chip_enable;
  endproperty
  a_chip_reset: assert property (p_chip_reset) else $error("chip register reset value wrong"); // R7

  property p_if_reset;
    @(posedge ref_clk) disable iff (rst)
      soft_rst |=> (regs_q[1] == RST_OTHER) && (regs_q[0] == RST_CHIP) && !regs_q[0][BIT_IF_RST];
  endproperty
  a_if_reset: assert property (p_if_reset) else $error("soft reset did not restore defaults"); // R6

  property p_global_pulse;
    @(posedge ref_clk) disable iff (rst)
      (wr_fire && req_q.addr == OFF_CHIP && req_q.data[BIT_GLOBAL_RST]) |=> nv_reset ##1 !nv_reset;
  endproperty
  a_global_pulse: assert property (p_global_pulse) else $error("global reset pulse missing"); // R5

  property p_fault_latch;
    @(posedge ref_clk) disable iff (rst)
      fault_set |=> fault_pin && fault_flag && !bias_drive_en;
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault not latched"); // R25

  property p_fault_clear;
    @(posedge ref_clk) disable iff (rst)
      !ctrl.bias_current_enable |=> !fault_pin;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared by bias enable low"); // R11

  property p_addr_nack;
    @(posedge link_clk) disable iff (lrst_s2_q)
      (st_q == ST_RX && scl_fall && cnt_q == BITS_PER_BYTE && idx_q == BYTE_DEV && !start_det && !stop_det
       && shift_q[7:1] != SLAVE_ADDR) |=> (st_q == ST_IDLE) && !sda_oe;
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged"); // R23

  property p_ack_hold;
    @(posedge link_clk) disable iff (lrst_s2_q)
      (st_q == ST_ACK) |-> sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("acknowledge not driven"); // R3

  property p_one_byte;
    @(posedge link_clk) disable iff (lrst_s2_q)
      (st_q == ST_ACK && idx_q == BYTE_DATA && scl_fall && !start_det && !stop_det) |=> st_q == ST_IDLE;
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("more than one data byte accepted"); // R24

  c_write: cover property (@(posedge ref_clk) disable iff (rst) wr_fire);
  c_read: cover property (@(posedge link_clk) disable iff (lrst_s2_q) st_q == ST_MACK);
  c_fault: cover property (@(posedge ref_clk) disable iff (rst) fault_set ##[1:20] !fault_q);

endmodule
`default_nettype wire

// ---- bench/ldc_master.sv ----
// Two-wire bus master model that stands outside the register bank.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`default_nettype none
module ldc_master (
  // Clock and resolved data wire
  input  wire logic ref_clk,
  input  wire logic sda_in,
  // Serial clock and data pull-down
  output var logic  scl,
  output var logic  sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bus idle, both lines high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // One phase of the serial clock, long enough for both domains
  task automatic hp;
    repeat (8) @(posedge ref_clk);
  endtask
  // Start or repeated start: data falls while the clock is high
  task automatic start;
    sda_pull <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_pull <= 1'b1;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  // Stop: data rises while the clock is high
  task automatic stop;
    sda_pull <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_pull <= 1'b0;
    hp();
  endtask
  // One bit out, wire sampled at the end of the high phase
  task automatic bit_x(input logic b, output logic r);
    sda_pull <= ~b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda_in;
    scl <= 1'b0;
    hp();
  endtask
  // Byte MSB first, then the ninth bit; ack true when the wire was low
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(last, r);
    ack = ~r;
  endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the laser driver register bank.
// Assumes a pulled-up data wire and a master model clocked by ref_clk.
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h expected %h", $time, a, e); end end
module testbench;
  import ldc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, flt = 1'b0, pdm = 1'b0;
  logic scl, pull, sda_o, sda_oe, pos_en, neg_en, bias_en, f_pin, f_flag, nv;
  ldc_ctrl_t ctrl;
  int err_total = 0, n_tests = 0, nv_cnt = 0;
  wire sda = ~(pull | (sda_oe & ~sda_o));
  // Clocks, link clock unrelated in phase
  always #20 ref_clk = ~ref_clk;
  initial #1.3 forever #3 link_clk = ~link_clk;
  always @(posedge ref_clk) if (nv === 1'b1) nv_cnt++;
  ldc_master i_ldc_master (.ref_clk(ref_clk), .sda_in(sda), .scl(scl), .sda_pull(pull));
  ldc_regs i_ldc_regs (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .fault_cond_i(flt), .pd_monitor_pin_i(pdm), .ctrl(ctrl),
    .positive_output_en(pos_en), .negative_output_en(neg_en), .bias_drive_en(bias_en),
    .fault_pin(f_pin), .fault_flag(f_flag), .nv_reset(nv));
  // Register write over the serial bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic k;
    i_ldc_master.start();
    i_ldc_master.xfer({SLAVE_ADDR, 1'b0}, 1'b1, q, k); `CHK(k, 1'b1)
    i_ldc_master.xfer(a, 1'b1, q, k); `CHK(k, 1'b1)
    i_ldc_master.xfer(d, 1'b1, q, k); `CHK(k, 1'b1)
    i_ldc_master.stop();
  endtask
  // Register read with repeated start and closing nack
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic k;
    i_ldc_master.start();
    i_ldc_master.xfer({SLAVE_ADDR, 1'b0}, 1'b1, q, k); `CHK(k, 1'b1)
    i_ldc_master.xfer(a, 1'b1, q, k); `CHK(k, 1'b1)
    i_ldc_master.start();
    i_ldc_master.xfer({SLAVE_ADDR, 1'b1}, 1'b1, q, k); `CHK(k, 1'b1)
    i_ldc_master.xfer(8'hFF, 1'b1, d, k);
    i_ldc_master.stop();
  endtask
  // Reset values and default output mode
  task automatic t_reset;
    logic [7:0] q;
    rd(OFF_CHIP, q); `CHK(q, RST_CHIP)
    `CHK(ctrl.chip_enable, 1'b1)
    `CHK({pos_en, neg_en}, 2'b11)
    rd(OFF_OUT_MODE, q); `CHK(q, 8'h00)
  endtask
  // Every register but the chip register written, read back and decoded; unmapped place ignored
  task automatic t_rw;
    logic [7:0] of[11] = '{8'h01, 8'h02, 8'h03, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h05};
    logic [7:0] vl[11] = '{8'h6B, 8'h5A, 8'hD6, 8'hA5, 8'h5C, 8'hFF, 8'h3A, 8'h81, 8'hC3, 8'hFE, 8'h77};
    logic [7:0] q;
    foreach (of[i]) wr(of[i], vl[i]);
    foreach (of[i]) begin
      rd(of[i], q); `CHK(q, (i == 10) ? 8'h00 : vl[i])
    end
    `CHK(ctrl, {1'b1, 8'h6B, 3'b111, 3'b110, 40'hA55CFF3A81, 8'hC3, 2'b10})
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CONVERTER, 8'(s)); `CHK(ctrl.converter_input_select, 3'(s))
    end
  endtask
  // Single-ended selection of positive then negative output
  task automatic t_mode;
    wr(OFF_OUT_MODE, 8'h40); `CHK({pos_en, neg_en}, 2'b10)
    wr(OFF_OUT_MODE, 8'hC0); `CHK({pos_en, neg_en}, 2'b01)
  endtask
  // Foreign address and a byte after the data byte are not acknowledged
  task automatic t_refuse;
    logic [7:0] q;
    logic k;
    i_ldc_master.start();
    i_ldc_master.xfer({7'h09, 1'b0}, 1'b1, q, k); `CHK(k, 1'b0)
    i_ldc_master.stop();
    i_ldc_master.start();
    i_ldc_master.xfer({SLAVE_ADDR, 1'b0}, 1'b1, q, k);
    i_ldc_master.xfer(OFF_MOD_LEVEL, 1'b1, q, k);
    i_ldc_master.xfer(8'h11, 1'b1, q, k);
    i_ldc_master.xfer(8'h22, 1'b1, q, k); `CHK(k, 1'b0)
    i_ldc_master.stop();
    rd(OFF_MOD_LEVEL, q); `CHK(q, 8'h11)
  endtask
  // Interface reset, chip disable, then global reset with storage pulse
  task automatic t_resets;
    logic [7:0] q;
    wr(OFF_CHIP, 8'h02);
    rd(OFF_MOD_LEVEL, q); `CHK(q, 8'h00)
    rd(OFF_CHIP, q); `CHK(q, RST_CHIP)
    wr(OFF_CHIP, 8'h3C);
    rd(OFF_CHIP, q); `CHK(q, 8'h38)
    `CHK(ctrl.chip_enable, 1'b0)
    wr(OFF_MOD_LEVEL, 8'h55);
    wr(OFF_CHIP, 8'h80); `CHK(nv_cnt, 1)
    rd(OFF_MOD_LEVEL, q); `CHK(q, 8'h00)
    rd(OFF_CHIP, q); `CHK(q, RST_CHIP)
  endtask
  // Fault latching, clearing by bias enable toggle, monitor pin trigger
  task automatic t_fault;
    wr(OFF_BIAS_LOOP, 8'h0C); `CHK(bias_en, 1'b1)
    flt <= 1'b1;
    repeat (20) @(posedge ref_clk);
    flt <= 1'b0;
    repeat (20) @(posedge ref_clk);
    `CHK({f_pin, f_flag, bias_en}, 3'b110)
    wr(OFF_BIAS_LOOP, 8'h08); `CHK(f_pin, 1'b0)
    wr(OFF_BIAS_LOOP, 8'h8C); `CHK(bias_en, 1'b1)
    pdm <= 1'b1;
    repeat (20) @(posedge ref_clk);
    pdm <= 1'b0;
    repeat (20) @(posedge ref_clk);
    `CHK({f_pin, bias_en}, 2'b10)
  endtask
  // Verdict and end of run
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog against a hung bus
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (12) @(posedge ref_clk);
    t_reset();
    t_rw();
    t_mode();
    t_refuse();
    t_resets();
    t_fault();
    end_of_test();
  end
endmodule
`default_nettype wire
